// *** core/scd_clock_divider.sv ***
// Sample clock divider with strobe realignment and duty cycle stabilizer
// Overview of operation
// - Input clock divided by a programmable integer ratio from one to eight.
// - Bits one and two of clock_sync_control pick every-strobe or first-strobe.
// - A valid alignment strobe returns the divider counter to its start.
// - Stabilizer on gives the internal clock a nominal half-period duty cycle.
// - Stabilizer treated as non-functional below about twenty megahertz.
// - Alignment strobe passes a synchroniser on the input clock before use.
// - Sampling instant stays on the rising edge of the internal clock.
`timescale 1ns/1ps
`default_nettype none
`include "scd_params.svh"
module scd_clock_divider #(
	parameter int IN_CLK_HZ = `SCD_CLK_HZ
) (
	input  wire logic                    clk_i,
	input  wire logic                    sys_rst_i,
	input  wire logic                    sync_i,
	input  wire logic                    reg_wr_i,
	input  wire logic [`SCD_ADDR_W-1:0]  reg_addr_i,
	input  wire scd_pkg::scd_byte_t      reg_wdata_i,
	output logic      [7:0]              reg_rdata_o,
	output logic                         sample_o,
	output logic                         div_clk_o,
	output logic                         dcs_active_o
);
	// Stabilizer loop cannot lock at slow input rates
	localparam bit DCS_USABLE = (IN_CLK_HZ >= `SCD_DCS_MIN_HZ);

	scd_pkg::scd_byte_t  clock_sync;
	scd_pkg::scd_byte_t  clock_divide;
	scd_pkg::scd_byte_t  duty_ctrl;
	scd_pkg::scd_ratio_t ratio_m1;
	scd_pkg::scd_ratio_t cnt;
	scd_pkg::scd_ratio_t next_cnt;
	scd_pkg::scd_ratio_t half;
	logic                s1, s2, s3;
	logic                sync_lvl;
	logic                sync_edge;
	logic                armed;
	logic                sync_valid;
	logic                wr_sync;
	logic                dcs_on;
	logic                sync_en;
	logic                sync_once;

	assign ratio_m1  = clock_divide[2:0];
	assign sync_en   = clock_sync[`SCD_BIT_SYNC_EN];
	assign sync_once = clock_sync[`SCD_BIT_SYNC_ONCE];
	assign wr_sync   = reg_wr_i && (reg_addr_i == `SCD_OFS_CLOCK_SYNC);
	assign dcs_on    = duty_ctrl[`SCD_BIT_DCS_EN] && DCS_USABLE;
	// Strobe accepted every time, or once per register write
	assign sync_valid = sync_edge && sync_en && (!sync_once || armed);

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			clock_sync   <= `SCD_RST_CLOCK_SYNC;
			clock_divide <= `SCD_RST_CLOCK_DIVIDE;
			duty_ctrl    <= `SCD_RST_DUTY_CTRL;
		end else if (reg_wr_i) begin
			if (reg_addr_i == `SCD_OFS_CLOCK_SYNC)
				clock_sync <= reg_wdata_i;
			if (reg_addr_i == `SCD_OFS_CLOCK_DIVIDE)
				clock_divide <= reg_wdata_i;
			if (reg_addr_i == `SCD_OFS_DUTY_CTRL)
				duty_ctrl <= reg_wdata_i;
		end
	end

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			reg_rdata_o <= 8'h00;
		end else begin
			unique case (reg_addr_i)
				`SCD_OFS_CLOCK_SYNC:   reg_rdata_o <= clock_sync;
				`SCD_OFS_CLOCK_DIVIDE: reg_rdata_o <= {5'h00, ratio_m1};
				`SCD_OFS_DUTY_CTRL:    reg_rdata_o <= {7'h00, dcs_on};
				default:               reg_rdata_o <= 8'h00;
			endcase
		end
	end

	// Three-stage synchroniser; s1 feeds only s2
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			s1 <= 1'b0;
			s2 <= 1'b0;
			s3 <= 1'b0;
		end else begin
			s1 <= sync_i;
			s2 <= s1;
			s3 <= s2;
		end
	end

	// Level accepted only once two stages agree
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			sync_lvl  <= 1'b0;
			sync_edge <= 1'b0;
		end else begin
			sync_edge <= (s2 == s3) && s2 && !sync_lvl;
			if (s2 == s3)
				sync_lvl <= s2;
		end
	end

	// A write re-arms and wins over a strobe in the same cycle
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i)
			armed <= 1'b0;
		else if (wr_sync)
			armed <= 1'b1;
		else if (sync_valid && sync_once)
			armed <= 1'b0;
	end

	always_comb begin
		if (sync_valid)
			next_cnt = 3'h0;
		else if (cnt >= ratio_m1)
			next_cnt = 3'h0;
		else
			next_cnt = cnt + 3'h1;
	end

	// High phase of ceil(N/2) cycles; N = ratio_m1 + 1
	assign half = 3'((4'(ratio_m1) + 4'h2) >> 1);

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			cnt          <= 3'h0;
			sample_o     <= 1'b0;
			div_clk_o    <= 1'b0;
			dcs_active_o <= 1'b0;
		end else begin
			cnt          <= next_cnt;
			sample_o     <= (next_cnt == 3'h0);
			dcs_active_o <= dcs_on;
			// Without the loop, only the sampling edge is regenerated
			if (dcs_on)
				div_clk_o <= (next_cnt < half);
			else
				div_clk_o <= (next_cnt == 3'h0);
		end
	end

	sequence s_pin_low;
		!sync_i [*4];
	endsequence
	sequence s_pin_high;
		sync_i [*4];
	endsequence

	property p_sync_through_sync;
		@(posedge clk_i) disable iff (sys_rst_i)
		s_pin_low ##1 s_pin_high |-> ##[0:2] sync_edge;
	endproperty
	a_sync_through_sync: assert property (p_sync_through_sync)
		else $error("synchronised strobe edge missing");

	property p_valid_resets;
		@(posedge clk_i) disable iff (sys_rst_i)
		sync_valid |=> (cnt == 3'h0) && sample_o;
	endproperty
	a_valid_resets: assert property (p_valid_resets)
		else $error("divider not realigned by strobe");

	property p_count_up;
		@(posedge clk_i) disable iff (sys_rst_i)
		!sync_valid && !reg_wr_i && (cnt < ratio_m1)
		|=> cnt == $past(cnt) + 3'h1;
	endproperty
	a_count_up: assert property (p_count_up)
		else $error("divider did not advance");

	property p_wrap;
		@(posedge clk_i) disable iff (sys_rst_i)
		(cnt >= ratio_m1) |=> (cnt == 3'h0);
	endproperty
	a_wrap: assert property (p_wrap)
		else $error("divider did not wrap");

	property p_every_strobe;
		@(posedge clk_i) disable iff (sys_rst_i)
		sync_edge && sync_en && !sync_once |=> cnt == 3'h0;
	endproperty
	a_every_strobe: assert property (p_every_strobe)
		else $error("strobe ignored in every-strobe mode");

	property p_once_blocks;
		@(posedge clk_i) disable iff (sys_rst_i)
		sync_valid && sync_once && !wr_sync |=>
			!armed ##0 !sync_valid ##1 (!sync_valid || $past(wr_sync));
	endproperty
	a_once_blocks: assert property (p_once_blocks)
		else $error("second strobe accepted in first-strobe mode");

	property p_sample_high;
		@(posedge clk_i) disable iff (sys_rst_i)
		sample_o |-> div_clk_o && (cnt == 3'h0);
	endproperty
	a_sample_high: assert property (p_sample_high)
		else $error("sampling edge lost");

	property p_no_dcs;
		@(posedge clk_i) disable iff (sys_rst_i)
		!dcs_active_o |-> (div_clk_o == sample_o);
	endproperty
	a_no_dcs: assert property (p_no_dcs)
		else $error("clock shaped while stabilizer inactive");

	property p_dcs_div4;
		@(posedge clk_i) disable iff (sys_rst_i)
		dcs_on && $stable(dcs_on) && $stable(ratio_m1) && !reg_wr_i &&
			ratio_m1 == 3'h3 && cnt == 3'h1 && !sync_valid
			|-> div_clk_o ##1 !div_clk_o;
	endproperty
	a_dcs_div4: assert property (p_dcs_div4)
		else $error("stabilized duty cycle wrong");
endmodule
`default_nettype wire

// *** core/scd_params.svh ***
// Offsets, field positions, reset values and rates for the sample clock path
`ifndef SCD_PARAMS_SVH
`define SCD_PARAMS_SVH
`define SCD_ADDR_W           13
`define SCD_OFS_CLOCK_SYNC   13'h100
`define SCD_OFS_CLOCK_DIVIDE 13'h00B
`define SCD_OFS_DUTY_CTRL    13'h009
`define SCD_BIT_SYNC_EN      1
`define SCD_BIT_SYNC_ONCE    2
`define SCD_BIT_DCS_EN       0
`define SCD_RST_CLOCK_SYNC   8'h00
`define SCD_RST_CLOCK_DIVIDE 8'h00
`define SCD_RST_DUTY_CTRL    8'h01
`define SCD_CLK_HZ           10000000
`define SCD_DCS_MIN_HZ       20000000
`endif

// *** core/scd_pkg.sv ***
// Types shared by the sample clock divider
package scd_pkg;
	typedef logic [2:0] scd_ratio_t;
	typedef logic [7:0] scd_byte_t;
endpackage

// *** tb/scd_strobe_src.sv ***
// Behavioural alignment strobe source
`timescale 1ns/1ps
`default_nettype none
module scd_strobe_src (
	input  wire logic       clk_i,
	input  wire logic       go_i,
	input  wire logic [7:0] gap_i,
	output logic            sync_o
);
	int cnt = 999;
	// Two strobes gap_i apart, 4 high, long low between
	always @(posedge clk_i) begin
		cnt = go_i ? 0 : cnt + 1;
		sync_o <= (cnt < 4) || (cnt >= gap_i && cnt < gap_i + 4);
	end
endmodule
`default_nettype wire

// *** tb/tb_top.sv ***
// Self-checking bench for the sample clock divider
`timescale 1ns/1ps
`default_nettype none
`include "scd_params.svh"
`define CHK(n, x, s) begin checked++; if ((x) !== (s)) begin n_fail++; \
	$display("ERROR %s exp %0h seen %0h", n, x, s); end end
module tb_top;
	logic               clk_i = 0, sys_rst_i = 1, reg_wr_i = 0, go = 0;
	logic [12:0]        reg_addr_i = '0, a;
	scd_pkg::scd_byte_t reg_wdata_i = '0;
	logic [7:0]         reg_rdata_o;
	logic               sample_o, div_clk_o, dcs_active_o, sync_i;
	logic [15:0]        e, q[$];
	bit                 rd_pend = 0, per_on = 0, armed = 0, prev = 0;
	int                 n_fail = 0, checked = 0, seed = 32'h924d;
	int                 cnt = 0, hi = 0, sc = 0;
	always #50 clk_i = ~clk_i;
	scd_clock_divider #(.IN_CLK_HZ(`SCD_DCS_MIN_HZ)) dut (.clk_i(clk_i),
		.sys_rst_i(sys_rst_i), .sync_i(sync_i), .reg_wr_i(reg_wr_i),
		.reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
		.reg_rdata_o(reg_rdata_o), .sample_o(sample_o),
		.div_clk_o(div_clk_o), .dcs_active_o(dcs_active_o));
	scd_strobe_src src (.clk_i(clk_i), .go_i(go), .gap_i(8'h11),
		.sync_o(sync_i));
	// Results are read at the falling edge, clear of the launch edge
	always @(negedge clk_i) begin
		if (rd_pend && q.size() != 0) begin
			e = q.pop_front();
			`CHK("rdata", e, {8'h00, reg_rdata_o})
			rd_pend = 0;
		end
		sc++;
		if (sync_i === 1'b1 && !prev) begin
			sc = 0;
			armed = 1;
		end
		prev = sync_i;
		if (armed && sample_o === 1'b1 && sc >= 5 && q.size() != 0) begin
			e = q.pop_front();
			`CHK("align", e, 16'(sc))
			armed = 0;
		end
		if (sample_o === 1'b1) begin
			if (per_on && q.size() != 0) begin
				e = q.pop_front();
				`CHK("period", e, {8'(cnt), 8'(hi)})
			end
			cnt = 0;
			hi = 0;
		end
		cnt++;
		hi += int'(div_clk_o);
	end
	task automatic final_report;
		$display("comparisons %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic drain;
		for (int i = 0; i < 40 && q.size() != 0; i++) @(negedge clk_i);
		if (q.size() != 0) begin
			n_fail++;
			$display("ERROR drain exp 0 seen %0d", q.size());
			final_report();
		end
	endtask
	task automatic wr(input logic [12:0] ad, input logic [7:0] d);
		@(negedge clk_i);
		reg_addr_i = ad;
		reg_wdata_i = d;
		reg_wr_i = 1'b1;
		@(negedge clk_i);
		reg_wr_i = 1'b0;
	endtask
	task automatic rd(input logic [12:0] ad, input logic [7:0] x);
		@(negedge clk_i);
		reg_addr_i = ad;
		q.push_back({8'h00, x});
		@(posedge clk_i);
		rd_pend = 1;
		drain();
	endtask
	task automatic per(input int r, input bit d);
		wr(`SCD_OFS_DUTY_CTRL, {7'h00, d});
		wr(`SCD_OFS_CLOCK_DIVIDE, 8'(r - 1));
		// Two microseconds of settling after each rate change
		repeat (20) @(negedge clk_i);
		`CHK("dcs", d, dcs_active_o)
		repeat (2) q.push_back({8'(r), d ? 8'((r + 1) / 2) : 8'h01});
		@(posedge clk_i) per_on = 1;
		drain();
		per_on = 0;
	endtask
	// Second strobe lands one cycle off the old phase, so a miss shows
	task automatic strobe(input logic [7:0] x2);
		q.push_back(16'h0005);
		q.push_back({8'h00, x2});
		@(negedge clk_i) go = 1;
		@(negedge clk_i) go = 0;
		drain();
	endtask
	initial begin
		repeat (2) @(posedge clk_i);
		@(negedge clk_i) sys_rst_i = 0;
		rd(`SCD_OFS_CLOCK_SYNC, `SCD_RST_CLOCK_SYNC);
		rd(`SCD_OFS_CLOCK_DIVIDE, `SCD_RST_CLOCK_DIVIDE);
		rd(`SCD_OFS_DUTY_CTRL, `SCD_RST_DUTY_CTRL);
		a = 13'h200 | 13'($random(seed) & 32'h1FF);
		wr(a, 8'($random(seed)));
		rd(a, 8'h00);
		$display("test registers done");
		for (int r = 1; r <= 8; r++) per(r, 1);
		// Stabilizer off only where a plain ratio allows it
		per(4, 0);
		rd(`SCD_OFS_CLOCK_DIVIDE, 8'h03);
		$display("test ratios done");
		per(8, 1);
		wr(`SCD_OFS_CLOCK_SYNC, 8'h02);
		strobe(8'h05);
		wr(`SCD_OFS_CLOCK_SYNC, 8'h06);
		strobe(8'h0C);
		$display("test alignment done");
		final_report();
	end
endmodule
`default_nettype wire
